// File: design/msbs_defines.svh
// Purpose: Constants of the motor stop and brake sequencer
// Assumes: Included by bare name, once per compilation unit
// Notes:   Offsets are byte addresses on the AHB-Lite slave

`ifndef MSBS_DEFINES_SVH
`define MSBS_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define MSBS_CTRL_OFS     8'h00
`define MSBS_STOPSEL_OFS  8'h04
`define MSBS_DELAY_OFS    8'h08
`define MSBS_BRAKE_OFS    8'h0C
`define MSBS_ALLOC_OFS    8'h10
`define MSBS_STATUS_OFS   8'h14

// ****************************************
// Field positions
// ****************************************
`define MSBS_SON_BIT      0
`define MSBS_ACLR_BIT     1
`define MSBS_RESTART_BIT  2
`define MSBS_G1_LSB       0
`define MSBS_OT_LSB       4
`define MSBS_G2_LSB       8
`define MSBS_ON_LSB       0
`define MSBS_OFF_LSB      16
`define MSBS_THR_LSB      0
`define MSBS_WAIT_LSB     8
`define MSBS_RBLIM_LSB    16

// ****************************************
// Reset values and limits
// ****************************************
`define MSBS_G1SEL_RST    2'h0
`define MSBS_OTSEL_RST    2'h0
`define MSBS_G2SEL_RST    3'h0
`define MSBS_ON_DLY_RST   12'h000
`define MSBS_OFF_DLY_RST  9'h000
`define MSBS_THR_RST      7'h64
`define MSBS_WAIT_RST     7'h32
`define MSBS_RBLIM_RST    9'h12C
`define MSBS_RBLIM_MAX    9'h15E
`define MSBS_ALLOC_RST    8'h00
`define MSBS_ALLOC_BK     4'h4

// ****************************************
// Stop select codes
// ****************************************
`define MSBS_G1_DBHOLD    2'h1
`define MSBS_G1_COAST     2'h2
`define MSBS_OT_DBHOLD    2'h1
`define MSBS_OT_CLAMP     2'h2
`define MSBS_G2_DBHOLD    3'h1
`define MSBS_G2_COAST     3'h2
`define MSBS_G2_REVDB     3'h3
`define MSBS_G2_REVCO     3'h4
`define MSBS_G2_WARN      3'h5

// ****************************************
// Timing
// ****************************************
`define MSBS_CLK_NS       100
`define MSBS_TICK_NS      1000000
`define MSBS_UNIT_MS      13'h00A

`endif

// File: design/msbs_pkg.sv
// Purpose: Types of the motor stop and brake sequencer
// Assumes: Used by scoped name only
// Notes:   Cause bits come from pins, drive bits go to the power stage

`default_nettype none

package msbs_pkg;

	typedef enum logic [2:0] {
		S_OFF   = 3'h0,
		S_ONW   = 3'h1,
		S_RUN   = 3'h2,
		S_REVB  = 3'h3,
		S_BWAIT = 3'h4,
		S_OFFD  = 3'h5,
		S_DONE  = 3'h6
	} msbs_state_t;

	typedef struct packed {
		logic g1;
		logic g2;
		logic safe;
		logic ot;
	} msbs_cause_t;

	typedef struct packed {
		logic       power;
		logic       dyn_brake;
		logic       ref_zero;
		logic       zero_clamp;
		logic       tq_en;
		logic [8:0] tq_limit;
	} msbs_drive_t;

	typedef struct packed {
		logic [2:0] g2;
		logic [1:0] ot;
		logic [1:0] g1;
	} msbs_sel_t;

endpackage

`default_nettype wire

// File: design/msbs_top.sv
// Purpose: Motor stop method and holding brake sequencer with AHB-Lite registers
// Assumes: motor_speed is unsigned rpm on core_clk; cause pins are asynchronous
// Notes:   Stop selects take effect on reset or on a restart write
// Operation
// - Stop on servo off, alarms, safe, overtravel
// - Group one select: db/coast, db/hold, coast
// - Overtravel select: db or reverse brake endings
// - Group two select: db, coast, reverse, none
// - Reverse brake forces zero speed reference
// - Group two reverse brake uses torque limit
// - Torque limit percent, 0 to 350, immediate
// - Group two code 5 only warns, clear needed
// - Brake engaged on servo off or alarm
// - Allocation code 4 routes brake to pins
// - Stopped: brake at once, power after delay
// - Positive on delay: brake first, then power
// - Negative on delay: power first, then brake
// - Alarm removes motor power at once, except in group two or overtravel reverse brake
// - Moving: brake below speed threshold
// - Moving: brake after wait time elapses
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.

`timescale 1ns/100ps
`default_nettype none
`include "msbs_defines.svh"

module msbs_top #(
	parameter int MS_CYCLES = `MSBS_TICK_NS / `MSBS_CLK_NS
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// Alarm, safe state and overtravel pins
	input  wire msbs_pkg::msbs_cause_t alarm_pin,
	// Motor feedback
	input  wire logic [15:0]           motor_speed,
	// Power stage and brake pin pairs
	output var msbs_pkg::msbs_drive_t  drive,
	output logic      [1:0]            brake_pin
);

	localparam logic [15:0] TICK_LAST = 16'(MS_CYCLES - 1);

	logic [3:0]            sy1, sy2, sy3, pin_f;
	msbs_pkg::msbs_cause_t live;
	msbs_pkg::msbs_state_t st, nst;
	msbs_pkg::msbs_drive_t next_drive;
	msbs_pkg::msbs_sel_t   prog, act;
	logic                  brake_rel, next_brake, servo_on;
	logic                  end_db_l, end_clamp_l, next_end_db, next_end_clamp;
	logic                  g1_lat, g2_lat;
	logic [11:0]           on_dly, on_mag;
	logic [8:0]            off_dly, rb_lim, wr_lim;
	logic [6:0]            thr, wait_t;
	logic [7:0]            alloc, a_addr;
	logic [12:0]           t_ms, off_ms, wait_ms;
	logic [15:0]           tick_cnt;
	logic                  a_valid, a_write, a_hit, a_word, rd_pend;
	logic [31:0]           rd_mux;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	genvar gi;
	for (gi = 0; gi < 4; gi++)
	begin : g_sync
		always_ff @(posedge core_clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				sy1[gi]   <= 1'h0;
				sy2[gi]   <= 1'h0;
				sy3[gi]   <= 1'h0;
				pin_f[gi] <= 1'h0;
			end
			else
			begin
				sy1[gi] <= alarm_pin[gi];
				sy2[gi] <= sy1[gi];
				sy3[gi] <= sy2[gi];
				if (sy2[gi] == sy3[gi])
					pin_f[gi] <= sy3[gi];
			end
		end
	end
	assign live = pin_f;

	// ****************************************
	// Bus decode
	// ****************************************
	wire addr_ph = hsel & hready & htrans[1];
	wire wr      = a_valid & a_write & a_hit & a_word;
	wire wr_ctrl = wr & (a_addr == `MSBS_CTRL_OFS);
	wire wr_sel  = wr & (a_addr == `MSBS_STOPSEL_OFS);
	wire wr_dly  = wr & (a_addr == `MSBS_DELAY_OFS);
	wire wr_brk  = wr & (a_addr == `MSBS_BRAKE_OFS);
	wire wr_all  = wr & (a_addr == `MSBS_ALLOC_OFS);
	wire aclr    = wr_ctrl & hwdata[`MSBS_ACLR_BIT];
	wire restart = wr_ctrl & hwdata[`MSBS_RESTART_BIT];
	assign wr_lim = hwdata[`MSBS_RBLIM_LSB +: 9];

	assign rd_mux = !a_hit ? 32'h0 :
		(a_addr == `MSBS_CTRL_OFS)    ? {31'h0, servo_on} :
		(a_addr == `MSBS_STOPSEL_OFS) ? {21'h0, prog.g2, 2'h0, prog.ot, 2'h0, prog.g1} :
		(a_addr == `MSBS_DELAY_OFS)   ? {7'h0, off_dly, 4'h0, on_dly} :
		(a_addr == `MSBS_BRAKE_OFS)   ? {7'h0, rb_lim, 1'h0, wait_t, 1'h0, thr} :
		(a_addr == `MSBS_ALLOC_OFS)   ? {24'h0, alloc} :
		(a_addr == `MSBS_STATUS_OFS)  ? {13'h0, act, pin_f, g1_lat, g2_lat,
			brake_rel, drive.power, 1'h0, st} : 32'h0;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_valid   <= 1'h0;
			a_write   <= 1'h0;
			a_hit     <= 1'h0;
			a_word    <= 1'h0;
			a_addr    <= 8'h00;
			rd_pend   <= 1'h0;
			hreadyout <= 1'h1;
			hresp     <= 1'h0;
			hrdata    <= 32'h0;
		end
		else
		begin
			a_valid   <= addr_ph;
			a_write   <= hwrite;
			a_hit     <= (haddr[31:8] == 24'h0);
			a_word    <= (hsize == 3'h2);
			a_addr    <= haddr[7:0];
			rd_pend   <= addr_ph & !hwrite;
			hreadyout <= !(addr_ph & !hwrite);
			hresp     <= 1'h0;
			if (rd_pend)
				hrdata <= rd_mux;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			servo_on <= 1'h0;
			prog     <= '{g2: `MSBS_G2SEL_RST, ot: `MSBS_OTSEL_RST, g1: `MSBS_G1SEL_RST};
			act      <= '{g2: `MSBS_G2SEL_RST, ot: `MSBS_OTSEL_RST, g1: `MSBS_G1SEL_RST};
			on_dly   <= `MSBS_ON_DLY_RST;
			off_dly  <= `MSBS_OFF_DLY_RST;
			thr      <= `MSBS_THR_RST;
			wait_t   <= `MSBS_WAIT_RST;
			rb_lim   <= `MSBS_RBLIM_RST;
			alloc    <= `MSBS_ALLOC_RST;
			g1_lat   <= 1'h0;
			g2_lat   <= 1'h0;
		end
		else
		begin
			if (wr_ctrl)
				servo_on <= hwdata[`MSBS_SON_BIT];
			if (wr_sel)
			begin
				prog.g1 <= hwdata[`MSBS_G1_LSB +: 2];
				prog.ot <= hwdata[`MSBS_OT_LSB +: 2];
				prog.g2 <= hwdata[`MSBS_G2_LSB +: 3];
			end
			// Selects only change the stop behaviour after a restart
			if (restart)
				act <= prog;
			if (wr_dly)
			begin
				on_dly  <= hwdata[`MSBS_ON_LSB +: 12];
				off_dly <= hwdata[`MSBS_OFF_LSB +: 9];
			end
			if (wr_brk)
			begin
				thr    <= hwdata[`MSBS_THR_LSB +: 7];
				wait_t <= hwdata[`MSBS_WAIT_LSB +: 7];
				rb_lim <= (wr_lim > `MSBS_RBLIM_MAX) ? `MSBS_RBLIM_MAX : wr_lim;
			end
			if (wr_all)
				alloc <= hwdata[7:0];
			// Alarms stay latched until cleared; a live alarm wins over the clear
			g1_lat <= live.g1 | (g1_lat & !aclr);
			g2_lat <= live.g2 | (g2_lat & !aclr);
		end
	end

	// ****************************************
	// Stop method decode
	// ****************************************
	wire g2_stop    = (act.g2 != `MSBS_G2_WARN);
	wire g2_rev     = (act.g2 == `MSBS_G2_REVDB) | (act.g2 == `MSBS_G2_REVCO);
	wire alarm_stop = g1_lat | (g2_lat & g2_stop);
	wire stop_req   = alarm_stop | live.ot | live.safe | !servo_on;
	wire use_g2     = !g1_lat & g2_lat & g2_stop;
	wire use_ot     = !g1_lat & !use_g2 & live.ot;
	wire g1_db      = (act.g1 != `MSBS_G1_COAST);
	wire g1_end_db  = (act.g1 == `MSBS_G1_DBHOLD);
	wire ot_end_db  = (act.ot == `MSBS_OT_DBHOLD);
	wire g2_db      = !g2_rev & (act.g2 != `MSBS_G2_COAST);
	wire g2_end_db  = (act.g2 == `MSBS_G2_DBHOLD) | (act.g2 == `MSBS_G2_REVDB);
	wire sel_rev    = use_g2 ? g2_rev : (use_ot & act.ot[1]);
	wire sel_db     = use_g2 ? g2_db : use_ot ? !act.ot[1] : g1_db;
	wire sel_end_db = use_g2 ? g2_end_db : use_ot ? ot_end_db : g1_end_db;
	wire sel_clamp  = use_ot & (act.ot == `MSBS_OT_CLAMP);
	wire stopped    = (motor_speed < {9'h000, thr});
	wire on_neg     = on_dly[11];
	assign on_mag   = on_neg ? 12'(-on_dly) : on_dly;
	assign off_ms   = 13'(off_dly) * `MSBS_UNIT_MS;
	assign wait_ms  = 13'(wait_t) * `MSBS_UNIT_MS;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		nst                 = st;
		next_drive          = drive;
		next_drive.tq_limit = rb_lim;
		next_brake          = brake_rel;
		next_end_db         = end_db_l;
		next_end_clamp      = end_clamp_l;
		case (st)
			msbs_pkg::S_OFF:
				if (servo_on && !stop_req)
				begin
					nst                  = msbs_pkg::S_ONW;
					next_drive.dyn_brake = 1'h0;
					next_drive.power     = on_neg;
					next_brake           = !on_neg;
				end
			msbs_pkg::S_ONW, msbs_pkg::S_RUN:
				if (stop_req)
				begin
					nst            = msbs_pkg::S_DONE;
					next_end_db    = sel_end_db;
					next_end_clamp = sel_clamp;
					if (sel_rev && !stopped)
					begin
						nst                 = msbs_pkg::S_REVB;
						next_drive.power    = 1'h1;
						next_drive.ref_zero = 1'h1;
						next_drive.tq_en    = 1'h1;
					end
					else if (sel_clamp)
						next_drive.zero_clamp = 1'h1;
					else if (!stopped)
					begin
						nst                  = msbs_pkg::S_BWAIT;
						next_drive.power     = 1'h0;
						next_drive.dyn_brake = sel_db;
					end
					else
					begin
						next_brake = 1'h0;
						if (alarm_stop)
						begin
							next_drive.power     = 1'h0;
							next_drive.dyn_brake = sel_end_db;
						end
						else
							nst = msbs_pkg::S_OFFD;
					end
				end
				else if (st == msbs_pkg::S_ONW && t_ms >= {1'h0, on_mag})
				begin
					nst              = msbs_pkg::S_RUN;
					next_drive.power = 1'h1;
					next_brake       = 1'h1;
				end
			msbs_pkg::S_REVB:
				if (stopped)
				begin
					nst                 = msbs_pkg::S_DONE;
					next_drive.ref_zero = 1'h0;
					next_drive.tq_en    = 1'h0;
					if (end_clamp_l)
						next_drive.zero_clamp = 1'h1;
					else
					begin
						next_drive.power     = 1'h0;
						next_drive.dyn_brake = end_db_l;
						next_brake           = 1'h0;
					end
				end
			msbs_pkg::S_BWAIT:
			begin
				if (stopped || t_ms >= wait_ms)
					next_brake = 1'h0;
				if (stopped)
				begin
					nst                  = msbs_pkg::S_DONE;
					next_drive.dyn_brake = drive.dyn_brake & end_db_l;
				end
			end
			msbs_pkg::S_OFFD:
				if (alarm_stop || t_ms >= off_ms)
				begin
					nst                  = msbs_pkg::S_DONE;
					next_drive.power     = 1'h0;
					next_drive.dyn_brake = end_db_l;
				end
			msbs_pkg::S_DONE:
			begin
				if (alarm_stop || !servo_on)
				begin
					next_drive.power      = 1'h0;
					next_drive.zero_clamp = 1'h0;
					next_brake            = 1'h0;
				end
				if (!servo_on && !g1_lat && !g2_lat && !live.ot && !live.safe)
					nst = msbs_pkg::S_OFF;
			end
			default:
				nst = msbs_pkg::S_OFF;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st          <= msbs_pkg::S_OFF;
			drive       <= '0;
			brake_rel   <= 1'h0;
			end_db_l    <= 1'h0;
			end_clamp_l <= 1'h0;
		end
		else
		begin
			st          <= nst;
			drive       <= next_drive;
			brake_rel   <= next_brake;
			end_db_l    <= next_end_db;
			end_clamp_l <= next_end_clamp;
		end
	end

	// Millisecond timer, cleared on every state change
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt <= 16'h0;
			t_ms     <= 13'h0;
		end
		else if (nst != st)
		begin
			tick_cnt <= 16'h0;
			t_ms     <= 13'h0;
		end
		else if (tick_cnt == TICK_LAST)
		begin
			tick_cnt <= 16'h0;
			if (t_ms != 13'h1FFF)
				t_ms <= t_ms + 13'h1;
		end
		else
			tick_cnt <= tick_cnt + 16'h1;
	end

	// ****************************************
	// Brake pin routing
	// ****************************************
	for (gi = 0; gi < 2; gi++)
	begin : g_pin
		always_ff @(posedge core_clk or negedge rst_n)
		begin
			if (!rst_n)
				brake_pin[gi] <= 1'h0;
			else
				brake_pin[gi] <= next_brake & (alloc[gi*4 +: 4] == `MSBS_ALLOC_BK);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking dcb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	alarm_power_cut_a: assert property (
		st == msbs_pkg::S_RUN && alarm_stop && !sel_rev |=> !drive.power)
		else $error("power kept after alarm");
	stopped_brake_a: assert property (
		st == msbs_pkg::S_RUN && !servo_on && !alarm_stop && !live.ot && !live.safe
		&& stopped |=> !brake_rel && drive.power && st == msbs_pkg::S_OFFD)
		else $error("stopped servo off sequence wrong");
	off_delay_a: assert property (
		st == msbs_pkg::S_OFFD && t_ms >= off_ms |=> !drive.power)
		else $error("power not removed after off delay");
	on_pos_a: assert property (
		st == msbs_pkg::S_OFF && nst == msbs_pkg::S_ONW && !on_neg
		|=> brake_rel && !drive.power)
		else $error("positive on delay order wrong");
	on_neg_a: assert property (
		st == msbs_pkg::S_OFF && nst == msbs_pkg::S_ONW && on_neg
		|=> drive.power && !brake_rel)
		else $error("negative on delay order wrong");
	rev_ref_zero_a: assert property (
		st == msbs_pkg::S_REVB |-> drive.ref_zero && drive.power)
		else $error("speed reference not zero in reverse brake");
	rev_torque_a: assert property (
		st == msbs_pkg::S_REVB |-> drive.tq_en && drive.tq_limit == $past(rb_lim))
		else $error("reverse brake torque limit wrong");
	torque_range_a: assert property (
		rb_lim <= `MSBS_RBLIM_MAX)
		else $error("torque limit out of range");
	brake_speed_a: assert property (
		st == msbs_pkg::S_BWAIT && stopped |=> !brake_rel && st == msbs_pkg::S_DONE)
		else $error("brake not engaged below threshold");
	brake_wait_a: assert property (
		st == msbs_pkg::S_BWAIT && t_ms >= wait_ms |=> !brake_rel)
		else $error("brake not engaged after wait");
	warn_keeps_run_a: assert property (
		st == msbs_pkg::S_RUN && servo_on && !g1_lat && !live.ot && !live.safe
		&& act.g2 == `MSBS_G2_WARN |=> st == msbs_pkg::S_RUN)
		else $error("warning code stopped the motor");
	timer_restart_a: assert property (
		nst != st |=> t_ms == 13'h0 && tick_cnt == 16'h0)
		else $error("timer not restarted");
	pin_route_a: assert property (
		alloc[3:0] != `MSBS_ALLOC_BK |=> !brake_pin[0])
		else $error("brake on unallocated pin");

endmodule

`default_nettype wire

// File: tb/msbs_motor_model.sv
// Purpose: Motor and power stage stand-in for the sequencer bench
// Assumes: Speed moves a few rpm per cycle while powered or braked
// Notes:   Coasting is slow so that the brake wait time can run out first

`timescale 1ns/100ps
`default_nettype none

module msbs_motor_model (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// Power stage and speed
	input  wire msbs_pkg::msbs_drive_t drive,
	input  wire logic [15:0]           target,
	output logic      [15:0]           motor_speed
);
	logic [1:0] div;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			motor_speed <= 16'h0000;
			div <= 2'h0;
		end
		else
		begin
			div <= div + 2'h1;
			if (drive.zero_clamp)
				motor_speed <= 16'h0000;
			else if (drive.power && drive.ref_zero)
				motor_speed <= (motor_speed > 16'h0008) ? motor_speed - 16'h0008 : 16'h0000;
			else if (drive.power && motor_speed < target)
				motor_speed <= motor_speed + 16'h0004;
			else if (drive.power)
				motor_speed <= target;
			else if (drive.dyn_brake)
				motor_speed <= (motor_speed > 16'h0004) ? motor_speed - 16'h0004 : 16'h0000;
			else if (div == 2'h0 && motor_speed != 16'h0000)
				motor_speed <= motor_speed - 16'h0001;
		end
	end
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Register and stop sequence bench of the sequencer
// Assumes: One millisecond is ten cycles here
// Notes:   Waits are bounded; a timeout counts as a mismatch

`timescale 1ns/100ps
`default_nettype none
`include "msbs_defines.svh"

module tb_top;
	logic                  core_clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  hsel = 1'b0;
	logic [31:0]           haddr = 32'h0000_0000;
	logic [1:0]            htrans = 2'h0;
	logic                  hwrite = 1'b0;
	logic [2:0]            hsize = 3'h2;
	logic [31:0]           hwdata = 32'h0000_0000;
	logic [31:0]           hrdata;
	logic                  hreadyout;
	logic                  hresp;
	msbs_pkg::msbs_cause_t alarm_pin = 4'h0;
	logic [15:0]           motor_speed;
	logic [15:0]           target = 16'h0000;
	msbs_pkg::msbs_drive_t drive;
	logic [1:0]            brake_pin;
	int                    error_cnt = 0;
	int                    check_count = 0;
	int                    n;
	logic [31:0]           r;

	always #50 core_clk = ~core_clk;

	msbs_top #(.MS_CYCLES(10)) dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.alarm_pin(alarm_pin), .motor_speed(motor_speed), .drive(drive),
		.brake_pin(brake_pin));

	msbs_motor_model motor (.core_clk(core_clk), .rst_n(rst_n), .drive(drive),
		.target(target), .motor_speed(motor_speed));

	// ****************************************
	// Checks and bus cycles
	// ****************************************
	task automatic give_verdict();
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic cond(input int k);
		case (k)
			0: cond = (brake_pin === 2'h3);
			1: cond = (drive.power === 1'b1);
			2: cond = (brake_pin === 2'h0);
			3: cond = (drive.power === 1'b0);
			4: cond = (motor_speed >= 16'd400);
			5: cond = (motor_speed < 16'd100);
			6: cond = (drive.zero_clamp === 1'b1);
			default: cond = 1'b0;
		endcase
	endfunction

	task automatic wait_c(input int k, input int lim, output int cnt);
		cnt = 0;
		while (!cond(k))
		begin
			if (cnt >= lim)
			begin
				error_cnt++;
				give_verdict();
			end
			@(posedge core_clk);
			cnt++;
		end
	endtask

	task automatic rdy();
		int t;
		t = 0;
		do
		begin
			@(posedge core_clk);
			t++;
			if (t > 20)
			begin
				error_cnt++;
				give_verdict();
			end
		end
		while (hreadyout !== 1'b1);
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask

	task automatic sel(input logic [31:0] s);
		int c;
		alarm_pin <= 4'h0;
		repeat (8) @(posedge core_clk);
		wr(`MSBS_CTRL_OFS, 32'h0000_0002);
		// A coasting motor must fall below threshold before the sequencer returns to off
		wait_c(5, 2000, c);
		wr(`MSBS_STOPSEL_OFS, s);
		wr(`MSBS_CTRL_OFS, 32'h0000_0004);
		repeat (6) @(posedge core_clk);
	endtask

	task automatic son();
		int c;
		target <= 16'h0000;
		wr(`MSBS_CTRL_OFS, 32'h0000_0001);
		wait_c(1, 400, c);
		repeat (510) @(posedge core_clk);
		target <= 16'h01F4;
		wait_c(4, 300, c);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(`MSBS_BRAKE_OFS, 32'h012C_3264);
		rd(`MSBS_STOPSEL_OFS, 32'h0000_0000);
		chk(brake_pin, 2'h0);
		wr(8'h18, 32'hFFFF_FFFF);
		rd(8'h18, 32'h0000_0000);
		wr(`MSBS_ALLOC_OFS, 32'h0000_0044);
		wr(`MSBS_DELAY_OFS, 32'h0001_0003);
		wr(`MSBS_CTRL_OFS, 32'h0000_0001);
		wait_c(0, 20, n);
		chk(drive.power, 1'b0);
		wait_c(1, 50, n);
		chk(n inside {[28:34]}, 1'b1);
		repeat (20) @(posedge core_clk);
		wr(`MSBS_CTRL_OFS, 32'h0000_0000);
		wait_c(2, 10, n);
		chk(drive.power, 1'b1);
		wait_c(3, 120, n);
		chk(n inside {[90:104]}, 1'b1);
		wr(`MSBS_DELAY_OFS, 32'h0000_0FFE);
		sel(32'h0000_0000);
		wr(`MSBS_CTRL_OFS, 32'h0000_0001);
		wait_c(1, 20, n);
		chk(brake_pin, 2'h0);
		wait_c(0, 40, n);
		chk(n inside {[18:24]}, 1'b1);
		repeat (510) @(posedge core_clk);
		target <= 16'h01F4;
		wait_c(4, 300, n);
		alarm_pin <= 4'h8;
		wait_c(3, 10, n);
		chk(n <= 7, 1'b1);
		chk(brake_pin, 2'h3);
		chk(drive.dyn_brake, 1'b1);
		wait_c(5, 500, n);
		wait_c(2, 4, n);
		wr(`MSBS_BRAKE_OFS, 32'h0190_0A64);
		rd(`MSBS_BRAKE_OFS, 32'h015E_0A64);
		chk(drive.tq_limit, 9'h15E);
		sel(32'h0000_0002);
		son();
		wr(`MSBS_CTRL_OFS, 32'h0000_0000);
		wait_c(3, 10, n);
		chk(drive.dyn_brake, 1'b0);
		wait_c(2, 1100, n);
		chk(n inside {[990:1010]}, 1'b1);
		chk(motor_speed >= 16'd100, 1'b1);
		sel(32'h0000_0020);
		son();
		alarm_pin <= 4'h1;
		repeat (8) @(posedge core_clk);
		chk({drive.power, drive.ref_zero, drive.tq_en}, 3'h7);
		wait_c(6, 200, n);
		chk(drive.power, 1'b1);
		sel(32'h0000_0300);
		son();
		alarm_pin <= 4'h4;
		repeat (8) @(posedge core_clk);
		chk({drive.power, drive.ref_zero, drive.tq_en}, 3'h7);
		chk(drive.tq_limit, 9'h15E);
		wait_c(3, 200, n);
		chk(motor_speed < 16'd100, 1'b1);
		chk(drive.dyn_brake, 1'b1);
		sel(32'h0000_0500);
		son();
		alarm_pin <= 4'h4;
		repeat (10) @(posedge core_clk);
		chk(drive.power, 1'b1);
		bus(1'b0, `MSBS_STATUS_OFS, 32'h0000_0000, r);
		chk(r[6], 1'b1);
		alarm_pin <= 4'h0;
		repeat (8) @(posedge core_clk);
		wr(`MSBS_CTRL_OFS, 32'h0000_0003);
		bus(1'b0, `MSBS_STATUS_OFS, 32'h0000_0000, r);
		chk(r[6], 1'b0);
		chk(drive.power, 1'b1);
		alarm_pin <= 4'h2;
		wait_c(3, 10, n);
		chk(drive.dyn_brake, 1'b1);
		give_verdict();
	end
endmodule

`default_nettype wire
